// >>> pkg/lpd_pkg.sv
// Shared constants and types for the DRAM command link model.
// Assumes a single 25 MHz clock on both ends; DDR data is modelled as pairs per cycle.
package lpd_pkg;
	localparam int          CLK_MHZ          = 25;
	localparam int          T_RP_NS          = 15;
	localparam int          T_WR_NS          = 15;
	localparam int          T_WTR_NS         = 2;
	localparam int          T_PDX_NS         = 10;
	localparam int          T_RCD_NS         = 15;
	// Least times round up to whole cycles, never below one
	localparam int          T_RP_CYC         = (T_RP_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (T_RP_NS * CLK_MHZ + 999) / 1000;
	localparam int          T_WR_CYC         = (T_WR_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (T_WR_NS * CLK_MHZ + 999) / 1000;
	localparam int          T_WTR_CYC        = (T_WTR_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (T_WTR_NS * CLK_MHZ + 999) / 1000;
	localparam int          T_PDX_CYC        = (T_PDX_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (T_PDX_NS * CLK_MHZ + 999) / 1000;
	localparam int          T_RCD_CYC        = (T_RCD_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (T_RCD_NS * CLK_MHZ + 999) / 1000;
	localparam int          NUM_BANKS        = 4;
	localparam int          AP_BIT           = 10;
	localparam logic [1:0]  BL_RESET         = 2'h1;
	// Command encoding: {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0]
	{
		LPD_CMD_DESEL = 4'h8,
		LPD_CMD_NOP   = 4'h7,
		LPD_CMD_ACT   = 4'h3,
		LPD_CMD_READ  = 4'h5,
		LPD_CMD_WRITE = 4'h4,
		LPD_CMD_PRE   = 4'h2
	} lpd_cmd_t;
	// Burst length code: 0=2, 1=4, 2=8
	typedef logic [1:0] lpd_bl_t;
endpackage : lpd_pkg

// >>> pkg/lpd_if.sv
// Link between the controller end and the DRAM end.
// Strobe and data are modelled as one pair per cycle; dq is two-way.
`timescale 1ns/10ps
interface lpd_if #(parameter int DW = 8, parameter int AW = 13);
	logic            cke;
	logic [3:0]      cmd;
	logic [1:0]      ba;
	logic [AW-1:0]   addr;
	logic            dqs;
	logic [2*DW-1:0] dq_wr;
	logic [1:0]      dm;
	logic [2*DW-1:0] dq_rd;
	logic            dq_rd_oe;
	modport ctrl (output cke, output cmd, output ba, output addr, output dqs, output dq_wr, output dm,
		input dq_rd, input dq_rd_oe);
	modport dram (input cke, input cmd, input ba, input addr, input dqs, input dq_wr, input dm,
		output dq_rd, output dq_rd_oe);
endinterface : lpd_if

// >>> logic/lpd_buf2.sv
// Two-entry buffer with valid/ready on both sides.
// Same clock on both sides; full and empty are exact.
`timescale 1ns/10ps
module lpd_buf2 #(parameter int W = 32, parameter int DEPTH = 2)
(
	input  wire logic         clock,
	input  wire logic         reset_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	// Pointers are one bit wide, so only two entries are served
	if (DEPTH != 2)
	begin : g_depth_chk
		$error("lpd_buf2 supports DEPTH 2 only");
	end
	logic [W-1:0] mem_reg [DEPTH];
	logic         wp_reg;
	logic         rp_reg;
	logic [1:0]   cnt_reg;
	logic         push;
	logic         pop;

	// Handshakes; full stalls the writer
	assign in_ready  = (cnt_reg != 2'h2);
	assign out_valid = (cnt_reg != 2'h0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rp_reg];

	// Storage
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
		else if (push)
			mem_reg[wp_reg] <= in_data;
	end

	// Pointers and fill level
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wp_reg  <= 1'b0;
			rp_reg  <= 1'b0;
			cnt_reg <= 2'h0;
		end
		else
		begin
			if (push) wp_reg <= ~wp_reg;
			if (pop) rp_reg <= ~rp_reg;
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : lpd_buf2

// >>> logic/lpd_ctrl.sv
// How it works
// R1 - Write-to-read delay counts from after last pair
// R2 - Write recovery counts from after last pair
// R3 - Other device READ may skip write-to-read
// R4 - Other device PRECHARGE may skip recovery
// R5 - A10 low on WRITE: no auto precharge
// R6 - Strobe keeps toggling over masked slots
// R7 - BL8 interrupted: drive unsuppressed strobe, mask
// R8 - WRITEs accepted to any bank
// R9 - Burst elements go to successive columns
// R10 - PRECHARGE closes rows; activate after row precharge
// R11 - A10 high all banks, else BA
// R12 - Idle bank needs ACTIVE before access
// R13 - CKE stays high during bursts
// R14 - Burst ends after its postamble
// R15 - CKE low enters precharge/active power-down
// R16 - Power-down switches off buffers
// R17 - CKE held low throughout power-down
// R18 - Exit on CKE high with NOP
// R19 - Only NOPs until exit time passes
// R20 - Power-down time bounded for refresh
// R21 - Truncated data beyond delay is masked
// R22 - First element on first strobe edge
// R23 - Controller tracks per-bank state and timers
// Controller end: takes user requests and issues timed commands.
// Assumes one device on the link; write data comes through the two-entry buffer.
`timescale 1ns/10ps
module lpd_ctrl #(
	parameter int DW     = 8,
	parameter int AW     = 13,
	parameter int PD_MAX = 100
)
(
	input  wire logic            clock,
	input  wire logic            reset_n,
	input  wire logic            req_valid,
	output logic                 req_ready,
	input  wire logic [3:0]      req_cmd,
	input  wire logic [1:0]      req_ba,
	input  wire logic [AW-1:0]   req_addr,
	input  wire logic            req_pd,
	input  wire logic [1:0]      req_bl,
	input  wire logic            wd_valid,
	output logic                 wd_ready,
	input  wire logic [2*DW-1:0] wd_data,
	input  wire logic [1:0]      wd_mask,
	output logic [1:0]           bank_open,
	lpd_if.ctrl                  link
);
	// Timers are eight bits wide, and the precharge-all bit must exist
	if (PD_MAX < 1 || PD_MAX > 255 || AW <= lpd_pkg::AP_BIT)
	begin : g_param_chk
		$error("lpd_ctrl parameters out of range");
	end
	typedef enum logic [1:0]
	{
		LPD_B_IDLE = 2'h0,
		LPD_B_ACTG = 2'h1,
		LPD_B_ACT  = 2'h2,
		LPD_B_PRE  = 2'h3
	} lpd_bank_t;
	typedef enum logic [1:0]
	{
		LPD_P_RUN  = 2'h0,
		LPD_P_DOWN = 2'h1,
		LPD_P_EXIT = 2'h2
	} lpd_pwr_t;

	lpd_bank_t  bst_reg [lpd_pkg::NUM_BANKS];
	logic [7:0] btim_reg [lpd_pkg::NUM_BANKS];
	lpd_pwr_t   pwr_reg;
	logic [7:0] pwr_cnt_reg;
	logic [3:0] burst_reg;
	logic [7:0] wtr_reg;
	logic [7:0] wr_reg;
	logic       go;
	logic       ok;
	logic       bk_ok;
	logic       is_wr;
	logic       is_rd;
	logic       is_pre;
	logic       is_act;
	logic [3:0] bl_pairs;
	logic       bv;
	logic       bready;
	logic [2*DW+1:0] bdata;

	// Write data path; buffer drains only while a burst runs
	lpd_buf2 #(.W(2*DW+2), .DEPTH(2)) u_buf (
		.clock     (clock),
		.reset_n   (reset_n),
		.in_valid  (wd_valid),
		.in_ready  (wd_ready),
		.in_data   ({wd_mask, wd_data}),
		.out_valid (bv),
		.out_ready (bready),
		.out_data  (bdata)
	);

	assign is_wr    = (req_cmd == lpd_pkg::LPD_CMD_WRITE);
	assign is_rd    = (req_cmd == lpd_pkg::LPD_CMD_READ);
	assign is_pre   = (req_cmd == lpd_pkg::LPD_CMD_PRE);
	assign is_act   = (req_cmd == lpd_pkg::LPD_CMD_ACT);
	assign bl_pairs = (req_bl == 2'h0) ? 4'h1 : (req_bl == 2'h1) ? 4'h2 : 4'h4;
	assign bready   = (burst_reg != 4'h0);

	// Legality check against bank state and timers
	always_comb
	begin
		bk_ok = 1'b1;
		if (is_rd || is_wr)
			bk_ok = (bst_reg[req_ba] == LPD_B_ACT); // R12 R23
		else if (is_act)
			bk_ok = (bst_reg[req_ba] == LPD_B_IDLE); // R10
		else if (is_pre && req_addr[lpd_pkg::AP_BIT])
		begin
			for (int i = 0; i < lpd_pkg::NUM_BANKS; i++)
				if (bst_reg[i] == LPD_B_ACTG || bst_reg[i] == LPD_B_PRE) bk_ok = 1'b0; // R11
		end
		else if (is_pre)
			bk_ok = (bst_reg[req_ba] != LPD_B_ACTG);
		ok = bk_ok && (pwr_reg == LPD_P_RUN) && !req_pd;
		// One device only, so the post-write delays are never skipped
		if (is_rd && (wtr_reg != 8'h0 || burst_reg != 4'h0)) ok = 1'b0; // R1 R3
		if (is_pre && (wr_reg != 8'h0 || burst_reg != 4'h0)) ok = 1'b0; // R2 R4 R21
		if (is_wr && (burst_reg != 4'h0 || !bv)) ok = 1'b0; // R13 R8
	end
	assign req_ready = ok;
	assign go        = req_valid && ok;

	// Per-bank state and timers
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			for (int i = 0; i < lpd_pkg::NUM_BANKS; i++)
			begin
				bst_reg[i]  <= LPD_B_IDLE;
				btim_reg[i] <= 8'h0;
			end
		else
			for (int i = 0; i < lpd_pkg::NUM_BANKS; i++)
			begin
				if (go && is_act && req_ba == i[1:0])
				begin
					bst_reg[i]  <= LPD_B_ACTG;
					btim_reg[i] <= 8'(lpd_pkg::T_RCD_CYC);
				end
				else if (go && is_pre && (req_addr[lpd_pkg::AP_BIT] || req_ba == i[1:0]))
				begin
					bst_reg[i]  <= LPD_B_PRE; // R10 R11
					btim_reg[i] <= 8'(lpd_pkg::T_RP_CYC);
				end
				else if (btim_reg[i] > 8'h1)
					btim_reg[i] <= btim_reg[i] - 8'h1;
				else if (btim_reg[i] == 8'h1)
				begin
					btim_reg[i] <= 8'h0;
					bst_reg[i]  <= (bst_reg[i] == LPD_B_ACTG) ? LPD_B_ACT : LPD_B_IDLE;
				end
			end
	end

	// Burst pair counter and post-write delays from after last pair
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			burst_reg <= 4'h0;
			wtr_reg   <= 8'h0;
			wr_reg    <= 8'h0;
		end
		else if (go && is_wr)
			burst_reg <= bl_pairs;
		else if (burst_reg != 4'h0 && bv)
		begin
			burst_reg <= burst_reg - 4'h1;
			if (burst_reg == 4'h1)
			begin
				wtr_reg <= 8'(lpd_pkg::T_WTR_CYC); // R1
				wr_reg  <= 8'(lpd_pkg::T_WR_CYC); // R2
			end
		end
		else
		begin
			if (wtr_reg != 8'h0) wtr_reg <= wtr_reg - 8'h1;
			if (wr_reg != 8'h0) wr_reg <= wr_reg - 8'h1;
		end
	end

	// Power-down sequencing
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pwr_reg     <= LPD_P_RUN;
			pwr_cnt_reg <= 8'h0;
		end
		else
			unique case (pwr_reg)
				LPD_P_RUN:
					if (req_pd && burst_reg == 4'h0) // R13
					begin
						pwr_reg     <= LPD_P_DOWN; // R15
						pwr_cnt_reg <= 8'(PD_MAX);
					end
				LPD_P_DOWN:
					if (!req_pd || pwr_cnt_reg == 8'h1) // R20
					begin
						pwr_reg     <= LPD_P_EXIT; // R18
						pwr_cnt_reg <= 8'(lpd_pkg::T_PDX_CYC);
					end
					else
						pwr_cnt_reg <= pwr_cnt_reg - 8'h1;
				LPD_P_EXIT:
					if (pwr_cnt_reg <= 8'h1)
						pwr_reg <= LPD_P_RUN; // R19
					else
						pwr_cnt_reg <= pwr_cnt_reg - 8'h1;
				default:
					pwr_reg <= LPD_P_RUN;
			endcase
	end

	// Command and data outputs registered
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			link.cke   <= 1'b1;
			link.cmd   <= lpd_pkg::LPD_CMD_NOP;
			link.ba    <= 2'h0;
			link.addr  <= '0;
			link.dqs   <= 1'b0;
			link.dq_wr <= '0;
			link.dm    <= 2'h3;
		end
		else
		begin
			link.cke  <= (pwr_reg != LPD_P_DOWN); // R17
			link.cmd  <= go ? req_cmd : lpd_pkg::LPD_CMD_NOP; // R19
			link.ba   <= req_ba;
			link.addr <= req_addr; // R5
			// Strobe runs on every burst slot, masked ones too
			link.dqs   <= bready && bv; // R6 R7 R22
			link.dq_wr <= bdata[2*DW-1:0];
			link.dm    <= (bready && bv) ? bdata[2*DW+1:2*DW] : 2'h3; // R21
		end
	end

	assign bank_open = {(bst_reg[3] == LPD_B_ACT) | (bst_reg[2] == LPD_B_ACT),
		(bst_reg[1] == LPD_B_ACT) | (bst_reg[0] == LPD_B_ACT)};
endmodule : lpd_ctrl

// >>> logic/lpd_dram.sv
// DRAM end: decodes commands, tracks rows, captures write pairs.
// Assumes the controller keeps the timing; link inputs are synchronised.
`timescale 1ns/10ps
module lpd_dram #(parameter int DW = 8, parameter int AW = 13)
(
	input  wire logic            clock,
	input  wire logic            reset_n,
	input  wire logic [1:0]      bl_code,
	lpd_if.dram                  link,
	output logic                 wr_valid,
	output logic [1:0]           wr_bank,
	output logic [AW-1:0]        wr_col,
	output logic [2*DW-1:0]      wr_data,
	output logic [1:0]           wr_mask,
	output logic [3:0]           row_open,
	output logic                 pd_active,
	output logic                 pd_precharge
);
	logic [3:0]      cmd_s1_reg, cmd_s2_reg;
	logic            cke_s1_reg, cke_s2_reg, cke_prev_reg;
	logic [1:0]      ba_s1_reg, ba_s2_reg;
	logic [AW-1:0]   ad_s1_reg, ad_s2_reg;
	logic            dqs_s1_reg, dqs_s2_reg;
	logic [2*DW+1:0] d_s1_reg, d_s2_reg;
	logic [3:0]      open_reg;
	logic [3:0]      left_reg;
	logic [AW-1:0]   col_reg;
	logic [1:0]      bank_reg;
	logic            ap_reg;
	logic [1:0]      pd_reg;
	logic            up;
	logic [AW-1:0]   col_mask;

	// Two-stage input synchronisers
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{cmd_s1_reg, cmd_s2_reg} <= {lpd_pkg::LPD_CMD_NOP, lpd_pkg::LPD_CMD_NOP};
			{cke_s1_reg, cke_s2_reg} <= 2'h3;
			{ba_s1_reg, ba_s2_reg}   <= 4'h0;
			{ad_s1_reg, ad_s2_reg}   <= '0;
			{dqs_s1_reg, dqs_s2_reg} <= 2'h0;
			{d_s1_reg, d_s2_reg}     <= '0;
		end
		else
		begin
			cmd_s1_reg <= link.cmd;
			cmd_s2_reg <= cmd_s1_reg;
			cke_s1_reg <= link.cke;
			cke_s2_reg <= cke_s1_reg;
			ba_s1_reg  <= link.ba;
			ba_s2_reg  <= ba_s1_reg;
			ad_s1_reg  <= link.addr;
			ad_s2_reg  <= ad_s1_reg;
			dqs_s1_reg <= link.dqs;
			dqs_s2_reg <= dqs_s1_reg;
			d_s1_reg   <= {link.dm, link.dq_wr};
			d_s2_reg   <= d_s1_reg;
		end
	end

	// Command inputs live only outside power-down; strobe capture is not gated
	assign up       = cke_s2_reg && cke_prev_reg; // R16
	assign col_mask = (bl_code == 2'h0) ? AW'(1) : (bl_code == 2'h1) ? AW'(3) : AW'(7);

	// Power-down state by CKE edges
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cke_prev_reg <= 1'b1;
			pd_reg       <= 2'h0;
		end
		else
		begin
			cke_prev_reg <= cke_s2_reg;
			if (cke_prev_reg && !cke_s2_reg)
				pd_reg <= (open_reg != 4'h0) ? 2'h2 : 2'h1; // R15
			else if (!cke_prev_reg && cke_s2_reg && (cmd_s2_reg == lpd_pkg::LPD_CMD_NOP
				|| cmd_s2_reg[3]))
				pd_reg <= 2'h0; // R18
		end
	end
	assign pd_precharge = pd_reg[0];
	assign pd_active    = pd_reg[1];

	// Row state per bank
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			open_reg <= 4'h0;
		else if (up)
		begin
			if (cmd_s2_reg == lpd_pkg::LPD_CMD_ACT)
				open_reg[ba_s2_reg] <= 1'b1;
			else if (cmd_s2_reg == lpd_pkg::LPD_CMD_PRE)
			begin
				if (ad_s2_reg[lpd_pkg::AP_BIT])
					open_reg <= 4'h0; // R11
				else
					open_reg[ba_s2_reg] <= 1'b0; // R10
			end
			else if (left_reg == 4'h1 && dqs_s2_reg && ap_reg)
				open_reg[bank_reg] <= 1'b0; // R5
		end
	end
	assign row_open = open_reg;

	// Write burst capture, one pair per strobe cycle
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			left_reg <= 4'h0;
			col_reg  <= '0;
			bank_reg <= 2'h0;
			ap_reg   <= 1'b0;
		end
		else if (up && cmd_s2_reg == lpd_pkg::LPD_CMD_WRITE)
		begin
			left_reg <= (bl_code == 2'h0) ? 4'h1 : (bl_code == 2'h1) ? 4'h2 : 4'h4; // R8
			col_reg  <= ad_s2_reg & ~AW'(1 << lpd_pkg::AP_BIT);
			bank_reg <= ba_s2_reg;
			ap_reg   <= ad_s2_reg[lpd_pkg::AP_BIT]; // R5
		end
		else if (left_reg != 4'h0 && dqs_s2_reg)
		begin
			left_reg <= left_reg - 4'h1; // R14
			col_reg  <= (col_reg & ~col_mask) | ((col_reg + AW'(2)) & col_mask); // R9
		end
		else if (up && (cmd_s2_reg == lpd_pkg::LPD_CMD_READ || cmd_s2_reg == lpd_pkg::LPD_CMD_PRE))
			left_reg <= 4'h0; // R21
	end

	// Captured pair to the array
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_valid <= 1'b0;
			wr_bank  <= 2'h0;
			wr_col   <= '0;
			wr_data  <= '0;
			wr_mask  <= 2'h0;
		end
		else
		begin
			wr_valid <= (left_reg != 4'h0) && dqs_s2_reg; // R22
			wr_bank  <= bank_reg;
			wr_col   <= col_reg;
			wr_data  <= d_s2_reg[2*DW-1:0];
			wr_mask  <= d_s2_reg[2*DW+1:2*DW]; // R21
		end
	end

	// Read data path not modelled here
	assign link.dq_rd    = '0;
	assign link.dq_rd_oe = 1'b0;
endmodule : lpd_dram

// >>> tb/lpd_chk.sv
// Checker on the command link between the two ends.
// Assumes the bench hands it the interface signals by name.
`timescale 1ns/10ps
module lpd_chk #(parameter int AW = 13, parameter int PD_MAX = 100)
(
	input wire logic          clock,
	input wire logic          reset_n,
	input wire logic          cke,
	input wire logic [3:0]    cmd,
	input wire logic [1:0]    ba,
	input wire logic [AW-1:0] addr,
	input wire logic          dqs
);
	int         pd_cnt_reg;
	int         up_cnt_reg;
	logic [3:0] act_reg;
	wire        is_nop = (cmd == lpd_pkg::LPD_CMD_NOP) || cmd[3];

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	// Gated cycles in a row; bounds power-down length
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			pd_cnt_reg <= 0;
		else
			pd_cnt_reg <= cke ? 0 : pd_cnt_reg + 1;

	// Cycles since the exit edge; commands wait out the exit time
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			up_cnt_reg <= lpd_pkg::T_PDX_CYC;
		else if (!cke)
			up_cnt_reg <= 0;
		else if (up_cnt_reg < lpd_pkg::T_PDX_CYC)
			up_cnt_reg <= up_cnt_reg + 1;

	// Rows seen opened on the wire; only registered while clocked
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			act_reg <= 4'h0;
		else if (cke && cmd == lpd_pkg::LPD_CMD_ACT)
			act_reg[ba] <= 1'b1;
		else if (cke && cmd == lpd_pkg::LPD_CMD_PRE)
			act_reg <= addr[10] ? 4'h0 : act_reg & ~(4'h1 << ba);
	end

	property p_burst_cke;
		cmd == lpd_pkg::LPD_CMD_WRITE |-> cke [*3];
	endproperty
	a_burst_cke: assert property (p_burst_cke) else $error("cke dropped in burst");
	property p_pd_entry;
		$fell(cke) |-> is_nop;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("entry without nop");
	property p_pd_exit;
		$rose(cke) |-> is_nop;
	endproperty
	a_pd_exit: assert property (p_pd_exit) else $error("exit without nop");
	property p_pdx;
		cke && up_cnt_reg < lpd_pkg::T_PDX_CYC |-> is_nop;
	endproperty
	a_pdx: assert property (p_pdx) else $error("command inside exit time");
	property p_pd_bound;
		pd_cnt_reg <= PD_MAX + 3;
	endproperty
	a_pd_bound: assert property (p_pd_bound) else $error("power-down too long");
	property p_first_edge;
		cmd == lpd_pkg::LPD_CMD_WRITE |-> !dqs ##1 dqs;
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("strobe not one cycle after write");
	property p_wtr;
		$fell(dqs) |-> cmd != lpd_pkg::LPD_CMD_READ;
	endproperty
	a_wtr: assert property (p_wtr) else $error("read inside write-to-read time");
	property p_wr;
		$fell(dqs) |-> cmd != lpd_pkg::LPD_CMD_PRE;
	endproperty
	a_wr: assert property (p_wr) else $error("precharge inside recovery time");
	property p_open;
		cke && cmd == lpd_pkg::LPD_CMD_WRITE |-> act_reg[ba];
	endproperty
	a_open: assert property (p_open) else $error("write to idle bank");
endmodule : lpd_chk

// >>> tb/tb.sv
// Bench joining controller and device ends through the link.
// Assumes a 25 MHz clock; model holds banks, beats and bursts.
`timescale 1ns/10ps
module tb;
	localparam int   DW = 8;
	localparam int   AW = 13;
	localparam int   PD = 20;
	logic            clock;
	logic            reset_n;
	logic            req_valid;
	logic            req_ready;
	logic [3:0]      req_cmd;
	logic [1:0]      req_ba;
	logic [AW-1:0]   req_addr;
	logic            req_pd;
	logic [1:0]      req_bl;
	logic            wd_valid;
	logic            wd_ready;
	logic [2*DW-1:0] wd_data;
	logic [1:0]      wd_mask;
	logic [1:0]      bank_open;
	logic [1:0]      bl_code;
	logic            wr_valid;
	logic [1:0]      wr_bank;
	logic [AW-1:0]   wr_col;
	logic [2*DW-1:0] wr_data;
	logic [1:0]      wr_mask;
	logic [3:0]      row_open;
	logic            pd_active;
	logic            pd_precharge;
	int              error_cnt;
	int              tests_run;
	int              beat;
	logic [3:0]      open_m;
	logic [AW+4:0]   wq[$];
	logic [2*DW+1:0] dq[$];

	lpd_if #(.DW(DW), .AW(AW)) lpd_if_i ();
	lpd_ctrl #(.DW(DW), .AW(AW), .PD_MAX(PD)) lpd_ctrl_i (.clock(clock), .reset_n(reset_n),
		.req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_ba(req_ba),
		.req_addr(req_addr), .req_pd(req_pd), .req_bl(req_bl), .wd_valid(wd_valid), .wd_ready(wd_ready),
		.wd_data(wd_data), .wd_mask(wd_mask), .bank_open(bank_open), .link(lpd_if_i.ctrl));
	lpd_dram #(.DW(DW), .AW(AW)) lpd_dram_i (.clock(clock), .reset_n(reset_n), .bl_code(bl_code),
		.link(lpd_if_i.dram), .wr_valid(wr_valid), .wr_bank(wr_bank), .wr_col(wr_col), .wr_data(wr_data),
		.wr_mask(wr_mask), .row_open(row_open), .pd_active(pd_active), .pd_precharge(pd_precharge));
	lpd_chk #(.AW(AW), .PD_MAX(PD)) lpd_chk_i (.clock(clock), .reset_n(reset_n), .cke(lpd_if_i.cke),
		.cmd(lpd_if_i.cmd), .ba(lpd_if_i.ba), .addr(lpd_if_i.addr), .dqs(lpd_if_i.dqs));

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : check

	// Bounded wait at falling edges, returns just after the next rise
	task automatic wait_is(ref logic s, input logic v);
		int n;
		@(negedge clock);
		for (n = 0; n < 60 && s !== v; n++)
			@(negedge clock);
		check(s, v, "handshake wait");
		@(posedge clock);
	endtask : wait_is

	task automatic issue(input lpd_pkg::lpd_cmd_t c, input logic [1:0] b, input logic [AW-1:0] a);
		@(posedge clock);
		req_valid <= 1'b1;
		req_cmd   <= c;
		req_ba    <= b;
		req_addr  <= a;
		wait_is(req_ready, 1'b1);
		req_valid <= 1'b0;
	endtask : issue

	// Valid held across beats so a long burst never runs dry
	task automatic push(input int beats);
		@(posedge clock);
		for (int k = 0; k < beats; k++)
		begin
			wd_valid <= 1'b1;
			wd_data  <= (2*DW)'($urandom);
			wd_mask  <= 2'($urandom);
			wait_is(wd_ready, 1'b1);
		end
		wd_valid <= 1'b0;
	endtask : push

	task automatic wr_burst(input logic [1:0] bl, input logic [1:0] b, input int beats);
		req_bl  <= bl;
		bl_code <= bl;
		fork
			push(beats);
			issue(lpd_pkg::LPD_CMD_WRITE, b, AW'($urandom) & 13'h03f8);
		join
	endtask : wr_burst

	task automatic settle();
		repeat (8) @(posedge clock);
		@(negedge clock);
		check(row_open, open_m, "rows");
		check(bank_open, {open_m[3] | open_m[2], open_m[1] | open_m[0]}, "bank summary");
		@(posedge clock);
	endtask : settle

	task automatic print_verdict();
		$display("Counts: %0d checks, %0d errors", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	// Reference model: taken commands, buffered beats, landed pairs
	always @(posedge clock)
	begin
		if (reset_n && req_valid && req_ready)
		begin
			if (req_cmd == lpd_pkg::LPD_CMD_ACT)
				open_m[req_ba] = 1'b1;
			if (req_cmd == lpd_pkg::LPD_CMD_PRE)
				open_m = req_addr[10] ? 4'h0 : open_m & ~(4'h1 << req_ba);
			if (req_cmd == lpd_pkg::LPD_CMD_WRITE)
				wq.push_back({req_ba, req_addr, 3'(1 << req_bl)});
		end
		if (wd_valid && wd_ready)
			dq.push_back({wd_data, wd_mask});
		if (wr_valid === 1'b1)
		begin
			check(wr_bank, wq[0][AW+4:AW+3], "bank");
			check(wr_col, wq[0][AW+2:3] + 2 * beat, "column");
			check({wr_data, wr_mask}, dq[0], "pair");
			void'(dq.pop_front());
			beat++;
			if (beat == wq[0][2:0])
			begin
				beat = 0;
				void'(wq.pop_front());
			end
		end
	end

	// Hang guard, far past the few hundred cycles expected
	initial
	begin
		#(40 * 20000);
		error_cnt++;
		print_verdict();
	end

	initial
	begin
		void'($urandom(32'h3f55));
		{reset_n, req_valid, req_pd, wd_valid, beat, error_cnt, tests_run} = '0;
		{req_ba, req_addr, wd_data, wd_mask, open_m} = '0;
		req_cmd = lpd_pkg::LPD_CMD_NOP;
		req_bl  = 2'h1;
		bl_code = lpd_pkg::BL_RESET;
		repeat (12) @(posedge clock);
		check({lpd_if_i.cke, lpd_if_i.dm, lpd_if_i.dqs}, 4'he, "reset link");
		reset_n <= 1'b1;
		// Every burst length to every bank, random columns
		for (int bl = 0; bl < 3; bl++)
		begin
			for (int b = 0; b < 4; b++)
			begin
				bl_code <= 2'(bl);
				issue(lpd_pkg::LPD_CMD_ACT, 2'(b), AW'($urandom));
				wr_burst(2'(bl), 2'(b), 1 << bl);
				settle();
			end
			issue(lpd_pkg::LPD_CMD_PRE, 2'(bl), 13'h0000);
			settle();
			issue(lpd_pkg::LPD_CMD_PRE, 2'($urandom), 13'h0400);
			settle();
		end
		// Fill the buffer until refused, then drain by a burst
		issue(lpd_pkg::LPD_CMD_ACT, 2'h0, 13'h0000);
		push(2);
		@(negedge clock);
		check(wd_ready, 1'b0, "buffer full");
		wr_burst(2'h1, 2'h0, 0);
		issue(lpd_pkg::LPD_CMD_READ, 2'h0, 13'h0000);
		settle();
		check(wd_ready, 1'b1, "buffer drained");
		// Precharge right behind a write must wait out recovery
		wr_burst(2'h0, 2'h0, 1);
		issue(lpd_pkg::LPD_CMD_PRE, 2'h0, 13'h0400);
		settle();
		// Precharge power-down, then active power-down with a row open
		for (int a = 0; a < 2; a++)
		begin
			if (a == 1)
				issue(lpd_pkg::LPD_CMD_ACT, 2'h1, 13'h0000);
			req_pd <= 1'b1;
			if (a == 1)
				wait_is(pd_active, 1'b1);
			else
				wait_is(pd_precharge, 1'b1);
			check({lpd_if_i.cke, pd_active, pd_precharge}, {2'b00, 1'b1} << a, "power-down");
			req_pd <= 1'b0;
			// Request pending across the exit; it must trail the exit time
			issue(lpd_pkg::LPD_CMD_PRE, 2'h2, 13'h0000);
			wait_is(lpd_if_i.cke, 1'b1);
			settle();
		end
		// Held request ended by the time limit
		req_pd <= 1'b1;
		wait_is(pd_active, 1'b1);
		wait_is(pd_active, 1'b0);
		req_pd <= 1'b0;
		settle();
		check(wq.size() + dq.size(), 0, "leftover beats");
		print_verdict();
	end
endmodule : tb
